// ==== include/esp_params.svh ====
`ifndef ESP_PARAMS_SVH
`define ESP_PARAMS_SVH

// ==========================================================
// Instruction codes, first byte after selection, MSB first
// ==========================================================
`define ESP_OP_CLR_LATCH 8'h04
`define ESP_OP_RD_STATUS 8'h05
`define ESP_OP_WR_STATUS 8'h01
// Codes owned by sibling blocks, only recognised as legal here
`define ESP_OP_SET_LATCH 8'h06
`define ESP_OP_RD_ARRAY  8'h03
`define ESP_OP_WR_ARRAY  8'h02

// ==========================================================
// Status byte field positions
// ==========================================================
`define ESP_SB_BUSY  0
`define ESP_SB_LATCH 1
`define ESP_SB_BP_LO 2
`define ESP_SB_BP_HI 3
`define ESP_SB_LOCK  7

// ==========================================================
// Reset values and protected region bases
// ==========================================================
// Non-volatile {lock, bp_hi, bp_lo} as delivered
`define ESP_NV_RESET   3'h0
`define ESP_QTR_BASE   11'h600
`define ESP_HALF_BASE  11'h400

// ==========================================================
// Self-timed status write cycle, in core clock cycles
// ==========================================================
`define ESP_WCYC_DEFAULT 1000

`endif

// ==== include/esp_pkg.sv ====
package esp_pkg;

    // ======================================================
    // Types
    // ======================================================
    // Serial transaction phase
    typedef enum logic [1:0] {
        ESP_PH_IDLE,
        ESP_PH_OPCODE,
        ESP_PH_BODY,
        ESP_PH_IGNORE
    } esp_phase_t;

    typedef logic [7:0]  esp_byte_t;   // Serial byte
    typedef logic [1:0]  esp_bp_t;     // Block-protect pair
    typedef logic [10:0] esp_addr_t;   // Array byte address

endpackage

// ==== core/esp_write_timer.sv ====
`timescale 1ns/1ps
`include "esp_params.svh"

// ==========================================================
// Self-timed write cycle counter
// ==========================================================
module esp_write_timer #(
    parameter int unsigned CYCLES = `ESP_WCYC_DEFAULT
) (
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_clk_en,
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);

    logic [31:0] cnt_r;    // Elapsed cycles
    logic        busy_r;   // Cycle running
    wire  logic  last_w;   // Final count reached, doubles as done

    // Start is ignored while running, so a cycle cannot be stretched
    assign last_w = busy_r && (cnt_r == 32'(CYCLES - 1));
    assign o_busy = busy_r;
    // Done marks the last busy cycle, so whatever the owner updates on
    // it lands on the very edge at which busy drops, with no idle gap
    assign o_done = last_w;

    // Count while running, pulse done on the last cycle
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            cnt_r  <= 32'h0;
            busy_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (last_w)
            begin
                busy_r <= 1'b0;
                cnt_r  <= 32'h0;
            end
            else if (busy_r)
                cnt_r <= cnt_r + 32'h1;
            else if (i_start)
                busy_r <= 1'b1;
        end
    end

endmodule // esp_write_timer

// ==== core/esp_status_protect.sv ====
`timescale 1ns/1ps
`include "esp_params.svh"

// What this block does
// - Clear-latch byte acts only after deselection
// - Latch cleared by reset, clear, write completions
// - Status read accepted at any time
// - Held selection repeats live status byte
// - Busy shows either write cycle running
// - Cleared latch rejects all write instructions
// - Protect bits stored, change only by write or reset
// - Protect bits frozen in hard protect mode, except by a write cycle begun before it
// - Lock plus low pin rejects status writes
// - Set-latch must precede every status write
// - Status write needs exactly one data byte
// - Byte-aligned deselect starts timed cycle
// - Busy during cycle, latch cleared at end
// - New protect values apply after cycle ends
// - Bits b6..b4,b1,b0 unwritten, b6..b4 zero
// - Writable when unlocked or protect pin high
// - Hard mode keeps region protected, rest writable
// - Hard mode entered in either event order
// - Raising protect pin or a reset leaves hard mode
// - Opcodes 04 clear, 05 read, 01 write
// - Protect codes select quarter, half, whole array
// - Clear-latch deselect falls before next edge
module esp_status_protect
#(
    parameter int unsigned WRITE_CYCLES = `ESP_WCYC_DEFAULT
) (
    input  wire logic            i_core_clk,
    input  wire logic            i_sys_rst,
    input  wire logic            i_clk_en,
    input  wire logic            i_spi_sck,
    input  wire logic            i_spi_cs_n,
    input  wire logic            i_spi_mosi,
    input  wire logic            i_wp_n,
    input  wire logic            i_set_latch,
    input  wire logic            i_array_write_done,
    input  wire logic            i_array_write_busy,
    input  wire esp_pkg::esp_addr_t i_array_addr,
    output logic                 o_spi_miso,
    output logic                 o_spi_miso_oe,
    output logic                 o_busy,
    output logic                 o_write_latch,
    output esp_pkg::esp_bp_t     o_block_protect,
    output logic                 o_status_lock,
    output logic                 o_hard_protect,
    output logic                 o_addr_protected,
    output logic                 o_array_write_ok
);
    import esp_pkg::*;

    // ======================================================
    // Pin synchronisers
    // ======================================================
    // Pin order: sck, cs_n, mosi, wp_n
    wire  logic [3:0] pins_w;     // Raw pins
    logic [3:0]       meta_r;     // First stage, read by stage two only
    logic [3:0]       sync_r;     // Second stage, safe to use
    logic             sck_d_r;    // Delayed clock for edge finding
    logic             cs_d_r;     // Delayed select for edge finding

    assign pins_w = {i_wp_n, i_spi_mosi, i_spi_cs_n, i_spi_sck};

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            // Two flops per pin against metastability
            always_ff @(posedge i_core_clk)
            begin
                if (i_sys_rst)
                begin
                    // Serial clock idles low, the rest idle high
                    meta_r[g] <= (g != 0);
                    sync_r[g] <= (g != 0);
                end
                else if (i_clk_en)
                begin
                    meta_r[g] <= pins_w[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    wire logic sck_w  = sync_r[0];   // Clean serial clock
    wire logic cs_n_w = sync_r[1];   // Clean select, low active
    wire logic mosi_w = sync_r[2];   // Clean serial data in
    wire logic wp_n_w = sync_r[3];   // Clean protect pin, low active

    wire logic sck_rise_w = sck_w && !sck_d_r;
    wire logic sck_fall_w = !sck_w && sck_d_r;
    wire logic cs_rise_w  = cs_n_w && !cs_d_r;

    // ======================================================
    // Decode helpers
    // ======================================================
    // opcode byte decode
    // Codes that some block of the device answers
    function automatic logic op_known(input esp_byte_t op);
        op_known = (op == `ESP_OP_CLR_LATCH) || (op == `ESP_OP_RD_STATUS)
                || (op == `ESP_OP_WR_STATUS) || (op == `ESP_OP_SET_LATCH)
                || (op == `ESP_OP_RD_ARRAY)  || (op == `ESP_OP_WR_ARRAY);
    endfunction

    // Address inside the region picked by the protect code
    function automatic logic in_region(input esp_bp_t bp, input esp_addr_t a);
        unique case (bp)
            2'h0: in_region = 1'b0;
            2'h1: in_region = (a >= `ESP_QTR_BASE);
            2'h2: in_region = (a >= `ESP_HALF_BASE);
            2'h3: in_region = 1'b1;
        endcase
    endfunction

    // ======================================================
    // State
    // ======================================================
    esp_phase_t phase_r;       // Transaction phase
    esp_phase_t phase_nxt;
    logic       seen_high_r;   // Select was high since reset
    logic [2:0] bit_cnt_r;     // Bit within byte
    logic [1:0] byte_cnt_r;    // Whole bytes, saturating
    esp_byte_t  shift_in_r;    // Incoming bits
    esp_byte_t  opcode_r;      // First byte
    esp_byte_t  data_r;        // Second byte
    esp_byte_t  shift_out_r;   // Outgoing status bits
    logic       miso_r;        // Output data flop
    logic       latch_r;       // Write enable latch
    logic       latch_nxt;
    logic [2:0] nv_r;          // {lock, bp_hi, bp_lo}, stored bits
    logic [2:0] pend_r;        // Values waiting for cycle end
    esp_byte_t  status_w;      // Live status byte
    wire  logic tmr_busy_w;    // Status write cycle running
    wire  logic tmr_done_w;    // Status write cycle end pulse

    wire esp_byte_t byte_w = {shift_in_r[6:0], mosi_w};
    wire logic byte_end_w  = sck_rise_w && (bit_cnt_r == 3'h7);
    wire logic hpm_w       = nv_r[2] && !wp_n_w;

    // ======================================================
    // Phase machine
    // ======================================================
    // Next phase from select and first byte
    always_comb
    begin
        phase_nxt = phase_r;
        unique case (phase_r)
            ESP_PH_IDLE:
                if (!cs_n_w && seen_high_r)
                    phase_nxt = ESP_PH_OPCODE;
            ESP_PH_OPCODE:
                if (cs_n_w)
                    phase_nxt = ESP_PH_IDLE;
                else if (byte_end_w)
                    // Unknown code drops the device off the bus
                    phase_nxt = op_known(byte_w) ? ESP_PH_BODY : ESP_PH_IGNORE;
            ESP_PH_BODY, ESP_PH_IGNORE:
                if (cs_n_w)
                    phase_nxt = ESP_PH_IDLE;
        endcase
    end

    // ======================================================
    // Execution decode on deselection
    // ======================================================
    wire logic in_body_w = (phase_r == ESP_PH_BODY);
    wire logic at_one_w  = (byte_cnt_r == 2'h1) && (bit_cnt_r == 3'h0);
    wire logic at_two_w  = (byte_cnt_r == 2'h2) && (bit_cnt_r == 3'h0);
    wire logic op_rd_w   = (opcode_r == `ESP_OP_RD_STATUS);

    // act only at deselect on exact byte
    wire logic exec_clr_w = cs_rise_w && in_body_w && at_one_w
                         && (opcode_r == `ESP_OP_CLR_LATCH);

    // writable with latch, outside hard mode
    wire logic wr_ok_w = latch_r && !hpm_w && !o_busy;

    wire logic exec_wr_w = cs_rise_w && in_body_w && at_two_w
                        && (opcode_r == `ESP_OP_WR_STATUS) && wr_ok_w;

    // clear sources, a set in the same cycle wins
    wire logic latch_clr_w = exec_clr_w || tmr_done_w || i_array_write_done;
    assign latch_nxt = i_set_latch ? 1'b1 : (latch_clr_w ? 1'b0 : latch_r);

    // ======================================================
    // Serial front end
    // ======================================================
    // Edge history, select history and phase
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            sck_d_r     <= 1'b0;
            cs_d_r      <= 1'b1;
            seen_high_r <= 1'b0;
            phase_r     <= ESP_PH_IDLE;
        end
        else if (i_clk_en)
        begin
            sck_d_r <= sck_w;
            cs_d_r  <= cs_n_w;
            phase_r <= phase_nxt;
            // Select must be seen high before first use
            if (cs_n_w)
                seen_high_r <= 1'b1;
        end
    end

    // Bit and byte counting on rising serial edges
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            shift_in_r <= 8'h00;
        end
        else if (i_clk_en)
        begin
            if (phase_r == ESP_PH_IDLE)
            begin
                bit_cnt_r  <= 3'h0;
                byte_cnt_r <= 2'h0;
            end
            else if (sck_rise_w)
            begin
                bit_cnt_r  <= bit_cnt_r + 3'h1;
                shift_in_r <= byte_w;
                // Saturate so surplus bytes never look aligned
                if (byte_end_w && (byte_cnt_r != 2'h3))
                    byte_cnt_r <= byte_cnt_r + 2'h1;
            end
        end
    end

    // Capture of opcode and data byte
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            opcode_r <= 8'h00;
            data_r   <= 8'h00;
        end
        else if (i_clk_en && byte_end_w)
        begin
            if (phase_r == ESP_PH_OPCODE)
                opcode_r <= byte_w;
            else if (in_body_w && (byte_cnt_r == 2'h1))
                data_r <= byte_w;
        end
    end

    // reload live status on every byte boundary
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            shift_out_r <= 8'h00;
            miso_r      <= 1'b0;
        end
        else if (i_clk_en && sck_fall_w && in_body_w && op_rd_w)
        begin
            if (bit_cnt_r == 3'h0)
            begin
                miso_r      <= status_w[7];
                shift_out_r <= {status_w[6:0], 1'b0};
            end
            else
            begin
                miso_r      <= shift_out_r[7];
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end
    end

    // ======================================================
    // Latch and stored protect bits
    // ======================================================
    // Stored bits reload the delivery value on reset, since no
    // real non-volatile cell exists in this model
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            latch_r <= 1'b0;
            nv_r    <= `ESP_NV_RESET;
            pend_r  <= `ESP_NV_RESET;
        end
        else if (i_clk_en)
        begin
            latch_r <= latch_nxt;
            // only b7, b3, b2 of the data are taken
            if (exec_wr_w)
                pend_r <= {data_r[`ESP_SB_LOCK], data_r[`ESP_SB_BP_HI],
                           data_r[`ESP_SB_BP_LO]};
            if (tmr_done_w)
                nv_r <= pend_r;
        end
    end

    // self-timed cycle, no serial clock needed
    esp_write_timer #(
        .CYCLES     (WRITE_CYCLES)
    ) u_timer (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_clk_en   (i_clk_en),
        .i_start    (exec_wr_w),
        .o_busy     (tmr_busy_w),
        .o_done     (tmr_done_w)
    );

    // ======================================================
    // Status byte and outputs
    // ======================================================
    // fixed layout, b6..b4 read zero
    // One driver for the whole byte: lock, zeros, bp_hi, bp_lo, latch, busy
    assign status_w = {nv_r[2], 3'h0, nv_r[1], nv_r[0], latch_r, o_busy};

    assign o_busy = tmr_busy_w || i_array_write_busy;

    assign o_spi_miso      = miso_r;
    assign o_spi_miso_oe   = in_body_w && op_rd_w && !cs_n_w;
    assign o_write_latch   = latch_r;
    assign o_block_protect = nv_r[1:0];
    assign o_status_lock   = nv_r[2];

    // pure level, follows pin in either order
    assign o_hard_protect = hpm_w;

    // region check, same in both modes
    assign o_addr_protected = in_region(nv_r[1:0], i_array_addr);

    // array writes also need the latch and idle device
    assign o_array_write_ok = latch_r && !o_busy && !o_addr_protected;

    // ======================================================
    // Checks
    // ======================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_wr_accept;
        i_clk_en && exec_wr_w;
    endsequence

    sequence s_busy_held;
        tmr_busy_w [*2];
    endsequence

    chk_latch_clear: assert property (
        i_clk_en && latch_clr_w && !i_set_latch |=> !latch_r)
        else $error("latch not cleared");

    chk_status_zero: assert property (
        status_w[6:4] == 3'h0 && status_w[0] == o_busy)
        else $error("status byte layout wrong");

    chk_busy_start: assert property (
        s_wr_accept |=> s_busy_held)
        else $error("busy not raised by status write");

    chk_latch_needed: assert property (
        exec_wr_w |-> latch_r)
        else $error("status write without latch");

    chk_hpm_reject: assert property (
        nv_r[2] && !wp_n_w |-> !exec_wr_w)
        else $error("status write in hard mode");

    chk_nv_hold: assert property (
        !tmr_done_w |=> nv_r == $past(nv_r))
        else $error("protect bits moved early");

    chk_done_apply: assert property (
        i_clk_en && tmr_done_w && !i_set_latch
        |=> !latch_r && nv_r == $past(pend_r))
        else $error("cycle end not applied");

    chk_full_protect: assert property (
        nv_r[1:0] == 2'h3 |-> o_addr_protected)
        else $error("whole array not protected");

    chk_clr_exact: assert property (
        i_clk_en && cs_rise_w && in_body_w && (opcode_r == `ESP_OP_CLR_LATCH)
        && (bit_cnt_r != 3'h0) && !tmr_done_w && !i_array_write_done
        |=> !$fell(latch_r))
        else $error("clear executed off boundary");

endmodule // esp_status_protect

// ==== test/esp_spi_master.sv ====
`timescale 1ns/1ps

// ==========================================================
// SPI bus master model, mode 0, 125 ns serial clock
// ==========================================================
module esp_spi_master (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    // Idle: deselected, clock parked low between frames
    initial
    begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // opcode first, MSB first, set by caller
    task automatic xfer(input int nb, input logic [23:0] tx, output logic [23:0] rx);
        rx = '0;
        o_cs_n = 1'b0;
        #62.5;
        for (int i = nb - 1; i >= 0; i--)
        begin
            o_mosi = tx[i];
            #62.5 o_sck = 1'b1;
            // Sample read data at the rising edge
            rx = {rx[22:0], i_miso};
            #62.5 o_sck = 1'b0;
        end
        // Deselect well before the next rise would come
        #30 o_cs_n = 1'b1;
        // Released line has no pull: show the inverse
        o_mosi = ~o_mosi;
        // gap long enough for the device to settle
        #250;
    endtask
endmodule // esp_spi_master

// ==== test/tb_esp_status_protect.sv ====
`timescale 1ns/1ps

// ==========================================================
// Bench for the status and protection block
// ==========================================================
module tb_esp_status_protect;
    import esp_pkg::*;
    // Long enough to read the status mid-cycle
    localparam int WCYC = 400;
    logic        clk, rst, wp_n, set_l, wdone, wbusy;
    esp_addr_t   addr;
    logic        sck, cs_n, mosi, miso, miso_oe;
    logic        busy, latch, lock, hard, prot, wok;
    esp_bp_t     bp;
    logic [23:0] rx;
    int          num_errors, tests_run;

    esp_status_protect #(.WRITE_CYCLES(WCYC)) uut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
        .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
        .i_wp_n(wp_n), .i_set_latch(set_l), .i_array_write_done(wdone),
        .i_array_write_busy(wbusy), .i_array_addr(addr),
        .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_busy(busy),
        .o_write_latch(latch), .o_block_protect(bp), .o_status_lock(lock),
        .o_hard_protect(hard), .o_addr_protected(prot), .o_array_write_ok(wok));

    esp_spi_master mst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

    // Core clock, 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ======================================================
    // Helpers
    // ======================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Inputs move only at falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic set_latch();
        tick(1);
        set_l = 1'b1;
        tick(1);
        set_l = 1'b0;
        tick(1);
    endtask

    // Two status bytes: the device repeats it while selected
    task automatic rd_status(input logic [7:0] exp);
        mst.xfer(24, 24'h050000, rx);
        chk(rx[15:8], exp, "status byte");
        chk(rx[7:0], exp, "repeat byte");
        tick(1);
    endtask

    // Frame length nb, right aligned so the opcode leads
    task automatic wr_status(input int nb, input logic [7:0] d);
        mst.xfer(nb, {8'h01, d, 8'h00} >> (24 - nb), rx);
        tick(2);
    endtask

    // Bounded wait for the write cycle to end
    task automatic wait_idle();
        for (int n = 0; n < 2000 && busy !== 1'b0; n++)
            tick(1);
        tick(2);
    endtask

    // ======================================================
    // Scenarios
    // ======================================================
    task automatic sc_reset();
        chk({lock, hard, bp, latch, busy, miso_oe}, 8'h00, "reset state");
        rd_status(8'h00);
    endtask

    task automatic sc_clear();
        set_latch();
        rd_status(8'h02);
        // Nine bits is not a whole clear instruction
        mst.xfer(9, 24'h000008, rx);
        chk(latch, 1'b1, "odd clear kept latch");
        mst.xfer(8, 24'h000004, rx);
        chk(latch, 1'b0, "clear latch");
        tick(1);
    endtask

    task automatic sc_no_latch();
        wr_status(16, 8'h8c);
        chk({busy, lock, bp}, 8'h00, "write without latch");
    endtask

    task automatic sc_cycle();
        set_latch();
        wr_status(16, 8'hff);
        chk(busy, 1'b1, "timed cycle busy");
        chk({lock, bp}, 8'h00, "old bits in force");
        rd_status(8'h03);
        wait_idle();
        chk(latch, 1'b0, "latch cleared at end");
        rd_status(8'h8c);
    endtask

    task automatic sc_regions();
        logic [10:0] al [6] = '{11'h000, 11'h3ff, 11'h400, 11'h5ff, 11'h600, 11'h7ff};
        logic        e;
        // Lock is still set from sc_cycle, with the pin high: still writable, and these writes clear it
        for (int b = 0; b < 4; b++)
        begin
            set_latch();
            wr_status(16, {4'h0, b[1:0], 2'h0});
            wait_idle();
            chk(bp, b[1:0], "protect code");
            set_latch();
            foreach (al[k])
            begin
                addr = al[k];
                tick(1);
                e = (b == 3) || (b == 2 && al[k] >= 11'h400) || (b == 1 && al[k] >= 11'h600);
                chk(prot, e, "region");
                chk(wok, !e, "array write ok");
            end
        end
    endtask

    task automatic sc_hard();
        // Pin low first, then lock set by a write
        wp_n = 1'b0;
        set_latch();
        wr_status(16, 8'h84);
        wait_idle();
        chk({lock, bp, hard}, 8'h0b, "lock after pin");
        set_latch();
        wr_status(16, 8'h0c);
        chk({busy, lock, bp}, 8'h05, "hard mode refuses");
        addr = 11'h000;
        tick(1);
        chk(wok, 1'b1, "open area");
        addr = 11'h7ff;
        tick(1);
        chk(wok, 1'b0, "guarded area");
        wp_n = 1'b1;
        tick(5);
        chk(hard, 1'b0, "pin high exits");
        wp_n = 1'b0;
        tick(5);
        chk(hard, 1'b1, "pin low after lock");
        wp_n = 1'b1;
        tick(5);
        // Latch still set: the refused write did not complete
        wr_status(16, 8'h00);
        wait_idle();
        chk({lock, bp, latch}, 8'h00, "unlocked");
    endtask

    task automatic sc_busy();
        wbusy = 1'b1;
        tick(2);
        chk(busy, 1'b1, "array cycle busy");
        set_latch();
        rd_status(8'h03);
        wr_status(16, 8'h0c);
        chk(bp, 2'h0, "write while busy");
        wbusy = 1'b0;
        wdone = 1'b1;
        tick(1);
        wdone = 1'b0;
        tick(2);
        chk(latch, 1'b0, "array done clears");
        set_latch();
        wr_status(24, 8'h0c);
        chk({busy, bp}, 8'h00, "long frame refused");
    endtask

    // ======================================================
    // Run control
    // ======================================================
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        wp_n = 1'b1;
        set_l = 1'b0;
        wdone = 1'b0;
        wbusy = 1'b0;
        addr = '0;
        num_errors = 0;
        tests_run = 0;
        tick(10);
        rst = 1'b0;
        // Select stays high a while so the first fall is seen
        tick(5);
        sc_reset();
        sc_clear();
        sc_no_latch();
        sc_cycle();
        sc_regions();
        sc_hard();
        sc_busy();
        complete_run();
    end

    // Whole run needs well under half a millisecond
    initial
    begin
        #500000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule // tb_esp_status_protect
